// ==== hdl/iocr_cell.sv ====
// I/O cell: input, output and tri-state register sections plus output gearbox.
// Assumes all inputs synchronous to clk; fast edge clocks are sampled levels.
// Summary of operation
// - Input, output and tri-state paths each have their own register section.
// - Bypass passes pad input to core combinationally and as a clock.
// - Optional fixed input delay; dynamic delay chosen by a five-bit select.
// - Single-rate input captures pad in one system-clock register.
// - Double-rate input samples both clock edges into two streams.
// - Right-edge capture qualified by read strobe clock, polarity swaps streams.
// - Right-edge output phases double-rate data by the write strobe clock.
// - First core data used in both rates, second only in double rate.
// - Core output enable registered onto pad tri-state control.
// - Clock enable and local set/reset govern all three sections.
// - Gearbox runs as 7:1, one 8:1 or two 4:1 serializers.
// - 7:1 uses bits 6..0, 8:1 bits 7..0, halves 3..0 and 7..4.
// - Stage one captures parallel data once per slow word.
// - Stage two moves the captured word toward the fast domain.
// - Stage three shifts out on the selected fast edge clock.
// - Gearbox reset clears all gearbox pipeline registers.
`timescale 1ns/1ns
`default_nettype none
module iocr_cell (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    // Input path
    input wire logic padIn,
    output logic inputBypassComb,
    output logic inputAsClock,
    output logic riseEdgeCapture,
    output logic fallOrSdrCapture,
    // Output and tri-state paths
    input wire logic cellCe,
    input wire logic cellLsr,
    input wire logic coreOutFirst,
    input wire logic coreOutSecond,
    input wire logic coreTristateCtrl,
    output logic padOut,
    output logic padTristateCtrl,
    // Right-edge strobe controls
    input wire logic strobeShiftReadClk,
    input wire logic strobeShiftWriteClk,
    input wire logic capturePolarityCtrl,
    // Output gearbox
    input wire logic [7:0] gearData,
    input wire logic [1:0] fastEdgeClk,
    input wire logic gearRst,
    output logic gearSerialOut,
    output logic gearSerialOutSecond,
    output logic gearWordTick
);
    iocr_pkg::iocr_ctrl_type ctrl_r, ctrl_nxt;
    logic [4:0] delaySel_r, delaySel_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [iocr_pkg::DELAY_TAPS-1:0] hist_r, hist_nxt;
    logic rise_r, rise_nxt, sdr_r, sdr_nxt, fall_r, fall_nxt;
    logic outFirst_r, outFirst_nxt, outSecond_r, outSecond_nxt, tri_r, tri_nxt;
    logic delayed, capEn, outPhase;
    logic edgePrev_r, edgePrev_nxt, shiftStep;
    logic [2:0] bitCnt_r, bitCnt_nxt, wordLen;
    logic [7:0] stage1_r, stage1_nxt, stage2_r, stage2_nxt, shift_r, shift_nxt;
    logic wordEnd;

    // Register port
    always_comb begin
        ctrl_nxt = ctrl_r;
        delaySel_nxt = delaySel_r;
        rdata_nxt = 32'h0000_0000;
        if (regWrite && regAddr == iocr_pkg::ADDR_CTRL) begin
            ctrl_nxt = iocr_pkg::iocr_ctrl_type'(regWdata[8:0]);
        end
        if (regWrite && regAddr == iocr_pkg::ADDR_DELAY) begin
            delaySel_nxt = regWdata[4:0];
        end
        if (regRead) begin
            unique case (regAddr)
                iocr_pkg::ADDR_CTRL: rdata_nxt = {23'h000000, ctrl_r};
                iocr_pkg::ADDR_DELAY: rdata_nxt = {27'h0000000, delaySel_r};
                iocr_pkg::ADDR_STATUS: rdata_nxt = {13'h0, shift_r, bitCnt_r, 2'h0,
                    tri_r, outSecond_r, outFirst_r, fall_r, sdr_r, rise_r};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_r <= iocr_pkg::iocr_ctrl_type'(iocr_pkg::CTRL_RESET[8:0]);
            delaySel_r <= iocr_pkg::DELAY_RESET;
            rdata_r <= 32'h0000_0000;
        end else begin
            ctrl_r <= ctrl_nxt;
            delaySel_r <= delaySel_nxt;
            rdata_r <= rdata_nxt;
        end
    end
    assign regRdata = rdata_r;

    // Input path
    assign inputBypassComb = padIn;
    assign inputAsClock = padIn;

    always_comb begin
        hist_nxt = {hist_r[iocr_pkg::DELAY_TAPS-2:0], padIn};
        // Delay line is a tap history, so delay is in whole clock cycles only
        if (!ctrl_r.delayEn || ctrl_r.bypass) begin
            delayed = padIn;
        end else if (ctrl_r.dynDelayEn) begin
            delayed = hist_r[delaySel_r];
        end else begin
            delayed = hist_r[iocr_pkg::FIXED_DELAY_TAP];
        end
        capEn = cellCe && (!ctrl_r.rightEdge || strobeShiftReadClk);
        rise_nxt = rise_r;
        sdr_nxt = sdr_r;
        fall_nxt = fall_r;
        if (cellLsr) begin
            rise_nxt = 1'b0;
            sdr_nxt = 1'b0;
            fall_nxt = 1'b0;
        end else if (capEn) begin
            rise_nxt = delayed;
            sdr_nxt = delayed;
            fall_nxt = delayed;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hist_r <= '0;
            rise_r <= 1'b0;
            sdr_r <= 1'b0;
        end else begin
            hist_r <= hist_nxt;
            rise_r <= rise_nxt;
            sdr_r <= sdr_nxt;
        end
    end

    // Falling-edge sample for the second double-rate stream
    always_ff @(negedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fall_r <= 1'b0;
        end else begin
            fall_r <= fall_nxt;
        end
    end

    always_comb begin
        if (!ctrl_r.ddrMode) begin
            riseEdgeCapture = sdr_r;
            fallOrSdrCapture = sdr_r;
        end else if (ctrl_r.rightEdge && capturePolarityCtrl) begin
            riseEdgeCapture = fall_r;
            fallOrSdrCapture = rise_r;
        end else begin
            riseEdgeCapture = rise_r;
            fallOrSdrCapture = fall_r;
        end
    end

    // Output and tri-state sections, each with registers of its own
    always_comb begin
        outFirst_nxt = outFirst_r;
        outSecond_nxt = outSecond_r;
        tri_nxt = tri_r;
        if (cellLsr) begin
            outFirst_nxt = 1'b0;
            outSecond_nxt = 1'b0;
            tri_nxt = 1'b0;
        end else if (cellCe) begin
            outFirst_nxt = coreOutFirst;
            outSecond_nxt = ctrl_r.outDdr ? coreOutSecond : 1'b0;
            tri_nxt = coreTristateCtrl;
        end
        // Clock-level mux may glitch on skew; pad buffer timing absorbs it
        outPhase = ctrl_r.rightEdge ? strobeShiftWriteClk : clk;
        padOut = (ctrl_r.outDdr && !outPhase) ? outSecond_r : outFirst_r;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            outFirst_r <= 1'b0;
            outSecond_r <= 1'b0;
            tri_r <= 1'b0;
        end else begin
            outFirst_r <= outFirst_nxt;
            outSecond_r <= outSecond_nxt;
            tri_r <= tri_nxt;
        end
    end
    assign padTristateCtrl = tri_r;

    // Output gearbox
    always_comb begin
        edgePrev_nxt = fastEdgeClk[ctrl_r.edgeSel];
        shiftStep = fastEdgeClk[ctrl_r.edgeSel] && !edgePrev_r;
        unique case (ctrl_r.gearMode)
            iocr_pkg::GM_SER7: wordLen = iocr_pkg::LEN_SER7;
            iocr_pkg::GM_EIGHT: wordLen = iocr_pkg::LEN_EIGHT;
            iocr_pkg::GM_FOUR: wordLen = iocr_pkg::LEN_FOUR;
            default: wordLen = iocr_pkg::LEN_EIGHT;
        endcase
        // Slow word boundary is derived from the fast count, keeping phases locked
        wordEnd = shiftStep && (bitCnt_r == wordLen);
        bitCnt_nxt = bitCnt_r;
        stage1_nxt = stage1_r;
        stage2_nxt = stage2_r;
        shift_nxt = shift_r;
        if (gearRst) begin
            bitCnt_nxt = 3'h0;
            stage1_nxt = 8'h00;
            stage2_nxt = 8'h00;
            shift_nxt = 8'h00;
        end else begin
            if (wordEnd) begin
                bitCnt_nxt = 3'h0;
                stage1_nxt = (ctrl_r.gearMode == iocr_pkg::GM_SER7) ?
                    {1'b0, gearData[6:0]} : gearData;
                stage2_nxt = stage1_r;
                shift_nxt = stage2_r;
            end else if (shiftStep) begin
                bitCnt_nxt = bitCnt_r + 3'h1;
                shift_nxt = {1'b0, shift_r[7:1]};
            end
        end
        gearSerialOut = shift_r[0];
        gearSerialOutSecond = (ctrl_r.gearMode == iocr_pkg::GM_FOUR) ?
            shift_r[iocr_pkg::SECOND_LANE] : 1'b0;
        gearWordTick = wordEnd;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            edgePrev_r <= 1'b0;
            bitCnt_r <= 3'h0;
            stage1_r <= 8'h00;
            stage2_r <= 8'h00;
            shift_r <= 8'h00;
        end else begin
            edgePrev_r <= edgePrev_nxt;
            bitCnt_r <= bitCnt_nxt;
            stage1_r <= stage1_nxt;
            stage2_r <= stage2_nxt;
            shift_r <= shift_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_bypass;
        inputBypassComb == padIn && inputAsClock == padIn;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass differs from pad");

    property p_sdr;
        (cellCe && !cellLsr && !ctrl_r.ddrMode && !ctrl_r.delayEn && !ctrl_r.rightEdge)
            ##1 $stable(ctrl_r) |-> fallOrSdrCapture == $past(padIn);
    endproperty
    a_sdr: assert property (p_sdr) else $error("sdr capture wrong");

    property p_dly;
        (ctrl_r.delayEn && ctrl_r.dynDelayEn && !ctrl_r.bypass && cellCe && !cellLsr
            && !ctrl_r.rightEdge) |=> sdr_r == $past(hist_r[delaySel_r]);
    endproperty
    a_dly: assert property (p_dly) else $error("dynamic delay tap wrong");

    property p_lsr;
        cellLsr |=> !rise_r && !sdr_r && !outFirst_r && !padTristateCtrl;
    endproperty
    a_lsr: assert property (p_lsr) else $error("local reset not applied");

    property p_tri;
        (cellCe && !cellLsr) |=> padTristateCtrl == $past(coreTristateCtrl);
    endproperty
    a_tri: assert property (p_tri) else $error("tristate not registered");

    property p_out;
        (!ctrl_r.outDdr && cellCe && !cellLsr) ##1 $stable(ctrl_r) |-> padOut == $past(coreOutFirst);
    endproperty
    a_out: assert property (p_out) else $error("sdr output wrong");

    property p_grst;
        gearRst |=> bitCnt_r == 3'h0 && shift_r == 8'h00 && stage1_r == 8'h00;
    endproperty
    a_grst: assert property (p_grst) else $error("gearbox reset ignored");

    property p_cnt;
        // A mode change may leave the count past the new length until it wraps from 7 back to 0
        (bitCnt_r <= wordLen) ##1 $stable(ctrl_r) |-> bitCnt_r <= wordLen;
    endproperty
    a_cnt: assert property (p_cnt) else $error("gear count beyond word");

    property p_pipe;
        (wordEnd && !gearRst) |=> stage2_r == $past(stage1_r) && shift_r == $past(stage2_r);
    endproperty
    a_pipe: assert property (p_pipe) else $error("gear pipeline skipped");

    property p_shift;
        (shiftStep && !wordEnd && !gearRst) |=> gearSerialOut == $past(shift_r[1]);
    endproperty
    a_shift: assert property (p_shift) else $error("serial order wrong");
endmodule
`default_nettype wire

// ==== hdl/iocr_pkg.sv ====
// Constants and carrier types for the I/O cell register and gearbox block.
// Assumes one 125 MHz clock; edge clocks arrive as sampled levels.
package iocr_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_DELAY = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [4:0] DELAY_RESET = 5'h00;
    localparam logic [4:0] FIXED_DELAY_TAP = 5'h04;
    localparam int DELAY_TAPS = 32;
    localparam logic [2:0] LEN_SER7 = 3'h6;
    localparam logic [2:0] LEN_EIGHT = 3'h7;
    localparam logic [2:0] LEN_FOUR = 3'h3;
    localparam int SECOND_LANE = 4;

    typedef enum logic [1:0] {
        GM_SER7 = 2'b00,
        GM_EIGHT = 2'b01,
        GM_FOUR = 2'b10
    } iocr_gear_type;

    typedef struct packed {
        logic edgeSel;
        iocr_gear_type gearMode;
        logic outDdr;
        logic rightEdge;
        logic dynDelayEn;
        logic delayEn;
        logic ddrMode;
        logic bypass;
    } iocr_ctrl_type;
endpackage

// ==== testbench/iocr_pad_model.sv ====
// Pad buffer model facing the I/O cell: loops the cell's output back when enabled.
// Assumes the bench supplies the external level; undriven pads show a toggling level.
`timescale 1ns/1ns
`default_nettype none
module iocr_pad_model (
    // Clock
    input wire logic clk,
    // Cell side
    input wire logic padOut,
    input wire logic padTristateCtrl,
    output logic padIn,
    // External side
    input wire logic extDrive,
    input wire logic extVal,
    input wire logic altHalf
);
    logic line_r = 1'b0;
    // Settles 2 ns after each clock edge so the cell never samples a moving level
    always @(clk) begin
        #2;
        if (padTristateCtrl) begin
            line_r = padOut;
        end else if (extDrive) begin
            line_r = (altHalf && !clk) ? !extVal : extVal;
        end else begin
            line_r = !line_r;
        end
    end
    assign padIn = line_r;
endmodule
`default_nettype wire

// ==== testbench/tb_iocr_cell.sv ====
// Self-checking bench for the I/O cell registers and output gearbox.
// Assumes the pad model in front of the cell and register access on the plain port.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; $display("Error at %0t: got %0h expected %0h", $time, (a), (b)); end end
module tb_iocr_cell;
    logic clk, arst_n, regWrite, regRead, padIn, cellCe, cellLsr, coreOutFirst, coreOutSecond, coreTristateCtrl;
    logic strobeShiftReadClk, strobeShiftWriteClk, capturePolarityCtrl, gearRst, extDrive, extVal, altHalf, edgeTb;
    logic inputBypassComb, inputAsClock, riseEdgeCapture, fallOrSdrCapture, padOut, padTristateCtrl;
    logic gearSerialOut, gearSerialOutSecond, gearWordTick, gearRun;
    logic [3:0] regAddr;
    logic [31:0] regWdata, regRdata, rdv;
    logic [7:0] gearData, gotA, gotB;
    logic [1:0] fastEdgeClk;
    int bad_count = 0;
    int cmp_count = 0;
    int l0, l1;
    iocr_cell iocr_cell_i (.clk, .arst_n, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .padIn,
        .inputBypassComb, .inputAsClock, .riseEdgeCapture, .fallOrSdrCapture, .cellCe, .cellLsr, .coreOutFirst,
        .coreOutSecond, .coreTristateCtrl, .padOut, .padTristateCtrl, .strobeShiftReadClk, .strobeShiftWriteClk,
        .capturePolarityCtrl, .gearData, .fastEdgeClk, .gearRst, .gearSerialOut, .gearSerialOutSecond, .gearWordTick);
    iocr_pad_model iocr_pad_model_i (.clk, .padOut, .padTristateCtrl, .padIn, .extDrive, .extVal, .altHalf);
    always #4 clk = ~clk;
    // Only the selected edge clock moves, so a wrong selection stalls the gearbox
    always @(posedge clk) begin
        if (gearRun) fastEdgeClk[edgeTb] <= ~fastEdgeClk[edgeTb];
    end
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        @(negedge clk);
        `CHK(regRdata, e)
        @(posedge clk);
    endtask
    // Looks just after the falling edge, once clock-level muxes and fall registers settle
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
        #1;
    endtask
    // Cycles from a pad step to the registered capture
    task automatic lat(output int n);
        extVal <= 1'b0;
        repeat (40) @(posedge clk);
        extVal <= 1'b1;
        n = 0;
        while (fallOrSdrCapture !== 1'b1) begin
            if (++n > 60) begin bad_count++; print_verdict; end
            @(negedge clk);
        end
        @(posedge clk);
    endtask
    task automatic wtick;
        int i;
        i = 0;
        @(negedge clk);
        while (gearWordTick !== 1'b1) begin
            if (++i > 100) begin bad_count++; print_verdict; end
            @(negedge clk);
        end
    endtask
    task automatic gear(input logic [1:0] m, input int len, input logic es, input logic [7:0] ea, input logic [7:0] eb);
        wr(4'h0, {23'h0, es, m, 6'h0});
        edgeTb <= es;
        gearRst <= 1'b1;
        @(posedge clk);
        gearRst <= 1'b0;
        @(negedge clk);
        `CHK(gearSerialOut, 1'b0)
        repeat (3) wtick;
        gotA = 8'h00;
        gotB = 8'h00;
        for (int i = 0; i <= len; i++) begin
            @(posedge clk);
            @(negedge clk);
            gotA[i] = gearSerialOut;
            gotB[i] = gearSerialOutSecond;
            @(posedge clk);
        end
        `CHK(gotA, ea)
        `CHK(gotB, eb)
    endtask
    initial begin
        {clk, arst_n, regWrite, regRead, cellCe, cellLsr, coreOutFirst, coreOutSecond, coreTristateCtrl} = 9'h000;
        {strobeShiftReadClk, strobeShiftWriteClk, capturePolarityCtrl, gearRst, extVal, altHalf, edgeTb} = 7'h00;
        {extDrive, gearRun, regAddr, regWdata, gearData, fastEdgeClk} = {2'b10, 46'h0};
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rdchk(4'h0, 32'h0000_0000);
        rdchk(4'h4, 32'h0000_0000);
        wr(4'h0, 32'hffff_ffff);
        rdchk(4'h0, 32'h0000_01ff);
        wr(4'h4, 32'hffff_ffff);
        rdchk(4'h4, 32'h0000_001f);
        wr(4'hc, 32'hffff_ffff);
        rdchk(4'hc, 32'h0000_0000);
        for (int v = 0; v < 2; v++) begin
            wr(4'h0, 32'h0000_0001);
            extVal <= v[0];
            settle(1);
            `CHK(inputBypassComb, v[0])
            `CHK(inputAsClock, v[0])
            @(posedge clk);
        end
        wr(4'h0, 32'h0000_0000);
        cellCe <= 1'b1;
        extVal <= 1'b1;
        settle(3);
        `CHK(fallOrSdrCapture, 1'b1)
        @(posedge clk);
        cellCe <= 1'b0;
        extVal <= 1'b0;
        settle(3);
        `CHK(fallOrSdrCapture, 1'b1)
        @(posedge clk);
        cellLsr <= 1'b1;
        extVal <= 1'b1;
        settle(2);
        `CHK(fallOrSdrCapture, 1'b0)
        @(posedge clk);
        {cellLsr, cellCe, altHalf} <= 3'b011;
        wr(4'h0, 32'h0000_0002);
        settle(3);
        `CHK(riseEdgeCapture, 1'b0)
        `CHK(fallOrSdrCapture, 1'b1)
        @(posedge clk);
        wr(4'h0, 32'h0000_0012);
        {strobeShiftReadClk, capturePolarityCtrl} <= 2'b11;
        settle(3);
        `CHK({riseEdgeCapture, fallOrSdrCapture}, 2'b10)
        @(posedge clk);
        // Pad pattern flips while the read clock is low, so only held captures match
        {strobeShiftReadClk, capturePolarityCtrl} <= 2'b00;
        extVal <= 1'b0;
        settle(3);
        `CHK({riseEdgeCapture, fallOrSdrCapture}, 2'b01)
        @(posedge clk);
        altHalf <= 1'b0;
        wr(4'h0, 32'h0000_0000);
        lat(l0);
        wr(4'h0, 32'h0000_0004);
        lat(l1);
        `CHK(l1 - l0, 5)
        wr(4'h4, 32'h0000_0009);
        @(posedge clk);
        wr(4'h0, 32'h0000_000c);
        lat(l1);
        `CHK(l1 - l0, 10)
        wr(4'h0, 32'h0000_0000);
        {coreOutFirst, coreOutSecond, coreTristateCtrl} <= 3'b101;
        settle(2);
        `CHK(padOut, 1'b1)
        `CHK(padTristateCtrl, 1'b1)
        @(posedge clk);
        rdchk(4'h8, 32'h0000_002f);
        wr(4'h0, 32'h0000_0020);
        settle(2);
        `CHK(padOut, 1'b0)
        @(posedge clk);
        #2;
        `CHK(padOut, 1'b1)
        wr(4'h0, 32'h0000_0030);
        strobeShiftWriteClk <= 1'b1;
        settle(2);
        `CHK(padOut, 1'b1)
        @(posedge clk);
        {coreTristateCtrl, gearRun, gearData} <= {2'b01, 8'ha7};
        gear(iocr_pkg::GM_SER7, 6, 1'b0, 8'h27, 8'h00);
        gear(iocr_pkg::GM_EIGHT, 7, 1'b1, 8'ha7, 8'h00);
        gear(iocr_pkg::GM_FOUR, 3, 1'b0, 8'h07, 8'h0a);
        print_verdict;
    end
endmodule
`default_nettype wire
